/* rtl/strap_mode_config_defs.vh */
`ifndef STRAP_MODE_CONFIG_DEFS_VH
`define STRAP_MODE_CONFIG_DEFS_VH

// ****************************************
// register offsets (printed offsets not multiples of four: index, byte addr = 4*index)
// ****************************************
`define IDX_SLEEP_CONTROL      8'h01
`define IDX_DISPLAY_ID_BRIDGE  8'h4F
`define IDX_BRIDGE_CONFIG      8'h54
`define IDX_LINK_PAIRING       8'h5B
`define IDX_REMOTE_ADDR        8'h70
`define IDX_STRAP_STATUS       8'h71
`define IDX_PIXEL_RATE         8'h72

// ****************************************
// field positions
// ****************************************
`define BIT_AUTO_SLEEP         7
`define BIT_DISPLAY_ID_SOURCE  0
`define BIT_AUX_AUDIO          1
`define BIT_REMOTE_ID_LOAD     5
`define BIT_EXT_OVERRIDE       7
`define BIT_CABLE_TYPE         7
`define BIT_FORCED_SINGLE      0
`define BIT_SECOND_CTRL_CHAN   1
`define BIT_STRAP_DONE         6

// ****************************************
// reset values and constants
// ****************************************
`define RST_REG8               8'h00
`define RST_REMOTE_ADDR        8'hA0
`define RST_PIXEL_MHZ          8'h00
`define RATE_MAX_NEW_MHZ       8'h60
`define RATE_LEGACY_MHZ        8'h55
`define STRAP_SETTLE_CYC       4'hF
`define AXI_OKAY               2'h0
`define AXI_SLVERR             2'h2
`define SYNC_STAGES            3

`endif

/* rtl/strap_level_decoder.v */
`include "strap_mode_config_defs.vh"

// thermometer of seven comparator outputs to a three-bit level code
module strap_level_decoder
(
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [6:0] level_above,
  output reg  [2:0] level_code,
  output reg        level_stable
);

  // ****************************************
  // three-flop synchroniser per comparator
  // ****************************************
  reg [6:0] s1_r;
  reg [6:0] s2_r;
  reg [6:0] s3_r;
  integer   i;
  reg [2:0] count_nxt;

  // sync chain
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_r <= 7'h00;
      s2_r <= 7'h00;
      s3_r <= 7'h00;
    end
    else
    begin
      s1_r <= level_above;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // count comparators passed: equals the level index
  always @*
  begin
    count_nxt = 3'h0;
    for (i = 0; i < 7; i = i + 1)
      count_nxt = count_nxt + {2'h0, s3_r[i]};
  end

  // code registered; stable once stages two and three agree
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      level_code   <= 3'h0;
      level_stable <= 1'b0;
    end
    else
    begin
      level_code   <= count_nxt; // RULE2
      level_stable <= (s2_r == s3_r);
    end
  end

endmodule

/* rtl/strap_mode_config.v */
// Contract
// [RULE1] sample both strap inputs at power-up and latch decoded bits into registers
// [RULE2] eight strap levels map to three-bit codes 000 to 111 per strap
// [RULE3] source select 0: search remote display id, fall back to internal copy
// [RULE4] source select 1: use external local display id source
// [RULE5] source select stored in bridge control bit 0 at 0x4F
// [RULE6] auto sleep stored in bit 7 of 0x01, 1 enables
// [RULE7] aux audio 0: video audio only; 1: plus auxiliary channel
// [RULE8] aux audio select stored in bit 1 of 0x54
// [RULE9] override 0: internal input control; 1: external controller via pins
// [RULE10] external override stored in bit 7 of 0x54
// [RULE11] cable type 0 twisted pair, 1 coaxial
// [RULE12] cable type stored in bit 7 of 0x5B
// [RULE13] remote load 0 uses internal copy, 1 copies remote into internal
// [RULE14] remote load stored in bit 5 of 0x54
// [RULE15] software can read and overwrite every latched setting
// [RULE16] single link carries all video, up to 96 MHz at 24 bit
// [RULE17] legacy receiver compatibility only below 85 MHz
// [RULE18] capable receiver lets secondary link serve as control channel
// [RULE19] forced single disables secondary transmitter and its back channel
// [RULE20] straps never resampled after the latch; writes rule until reset
`include "strap_mode_config_defs.vh"

module strap_mode_config
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [6:0]  strap0_above,
  input  wire [6:0]  strap1_above,
  input  wire        remote_id_found,
  input  wire        receiver_new_gen,
  input  wire        receiver_ctrl_capable,
  input  wire [7:0]  pixel_rate_mhz,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         use_remote_display_id,
  output reg         use_internal_display_id,
  output reg         use_external_display_id,
  output reg         copy_remote_to_internal,
  output reg         auto_sleep_enable,
  output reg         aux_audio_mix,
  output reg         external_control_override,
  output reg         cable_type_select,
  output reg         secondary_tx_enable,
  output reg         secondary_back_channel_enable,
  output reg         secondary_ctrl_channel,
  output reg         rate_ok,
  output reg  [7:0]  remote_display_id_addr,
  output reg         strap_latched
);

  // ****************************************
  // strap capture
  // ****************************************
  wire [2:0] code0;
  wire [2:0] code1;
  wire       stable0;
  wire       stable1;
  reg  [3:0] settle_r;
  reg        latched_r;
  reg  [5:0] strap_raw_r;

  strap_level_decoder u_dec0
  (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .level_above  (strap0_above),
    .level_code   (code0),
    .level_stable (stable0)
  );

  strap_level_decoder u_dec1
  (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .level_above  (strap1_above),
    .level_code   (code1),
    .level_stable (stable1)
  );

  // latch fires once, on the first cycle the settle count is full
  wire latch_now = !latched_r && (settle_r == `STRAP_SETTLE_CYC);

  // settle counter, counts while both straps steady
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      settle_r    <= 4'h0;
      latched_r   <= 1'b0;
      strap_raw_r <= 6'h00;
    end
    else if (!latched_r) // RULE20
    begin
      if (!(stable0 && stable1))
        settle_r <= 4'h0;
      else if (settle_r != `STRAP_SETTLE_CYC)
        settle_r <= settle_r + 4'h1;
      if (latch_now)
      begin
        latched_r   <= 1'b1; // RULE1
        strap_raw_r <= {code1, code0};
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] sleep_control_r;
  reg [7:0] display_id_bridge_control_r;
  reg [7:0] bridge_configuration_r;
  reg [7:0] link_pairing_control_r;
  reg [7:0] remote_addr_r;

  // word index from byte address
  function [7:0] reg_index;
    input [31:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  // merge write strobe lane 0
  function [7:0] merge8;
    input [7:0] old;
    input [7:0] data;
    input       en;
    begin
      merge8 = en ? data : old;
    end
  endfunction

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  reg        aw_have_r;
  reg        w_have_r;
  reg [31:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;

  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;

  wire [7:0] wr_idx = reg_index(aw_addr_r);
  wire       wr_go  = aw_have_r && w_have_r && !s_axi_bvalid;
  // unmapped indexes answer with an error and store nothing
  wire       wr_map = (wr_idx == `IDX_SLEEP_CONTROL) || (wr_idx == `IDX_DISPLAY_ID_BRIDGE) ||
                      (wr_idx == `IDX_BRIDGE_CONFIG) || (wr_idx == `IDX_LINK_PAIRING) ||
                      (wr_idx == `IDX_REMOTE_ADDR) || (wr_idx == `IDX_STRAP_STATUS) ||
                      (wr_idx == `IDX_PIXEL_RATE);
  wire       wr_en  = wr_go && w_strb_r[0];

  // address/data capture in either order, then response
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r    <= 1'b0;
      w_have_r     <= 1'b0;
      aw_addr_r    <= 32'h00000000;
      w_data_r     <= 32'h00000000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `AXI_OKAY : `AXI_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // register file: strap latch loads, software writes after
  // latch wins a same-cycle write, which is then lost
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sleep_control_r             <= `RST_REG8;
      display_id_bridge_control_r <= `RST_REG8;
      bridge_configuration_r      <= `RST_REG8;
      link_pairing_control_r      <= `RST_REG8;
      remote_addr_r               <= `RST_REMOTE_ADDR; // RULE3
    end
    else if (latch_now)
    begin
      display_id_bridge_control_r[`BIT_DISPLAY_ID_SOURCE] <= code0[2]; // RULE5
      sleep_control_r[`BIT_AUTO_SLEEP]    <= code0[1]; // RULE6
      bridge_configuration_r[`BIT_AUX_AUDIO]      <= code0[0]; // RULE8
      bridge_configuration_r[`BIT_EXT_OVERRIDE]   <= code1[2]; // RULE10
      link_pairing_control_r[`BIT_CABLE_TYPE]     <= code1[1]; // RULE12
      bridge_configuration_r[`BIT_REMOTE_ID_LOAD] <= code1[0]; // RULE14
    end
    else if (wr_en)
    begin
      case (wr_idx) // RULE15
        `IDX_SLEEP_CONTROL:
          sleep_control_r <= merge8(sleep_control_r, w_data_r[7:0], 1'b1);
        `IDX_DISPLAY_ID_BRIDGE:
          display_id_bridge_control_r <= merge8(display_id_bridge_control_r, w_data_r[7:0], 1'b1);
        `IDX_BRIDGE_CONFIG:
          bridge_configuration_r <= merge8(bridge_configuration_r, w_data_r[7:0], 1'b1);
        `IDX_LINK_PAIRING:
          link_pairing_control_r <= merge8(link_pairing_control_r, w_data_r[7:0], 1'b1);
        `IDX_REMOTE_ADDR:
          remote_addr_r <= merge8(remote_addr_r, w_data_r[7:0], 1'b1); // RULE3
        default:
          remote_addr_r <= remote_addr_r;
      endcase
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  // status byte: latch flag above the two decoded strap codes
  reg [7:0] strap_status;

  always @*
  begin
    strap_status                  = {2'h0, strap_raw_r};
    strap_status[`BIT_STRAP_DONE] = latched_r;
  end

  assign s_axi_arready = !s_axi_rvalid;
  wire [7:0] rd_idx = reg_index(s_axi_araddr);

  // one-cycle read answer
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `AXI_OKAY;
      case (rd_idx)
        `IDX_SLEEP_CONTROL:     s_axi_rdata <= {24'h000000, sleep_control_r}; // RULE15
        `IDX_DISPLAY_ID_BRIDGE: s_axi_rdata <= {24'h000000, display_id_bridge_control_r};
        `IDX_BRIDGE_CONFIG:     s_axi_rdata <= {24'h000000, bridge_configuration_r};
        `IDX_LINK_PAIRING:      s_axi_rdata <= {24'h000000, link_pairing_control_r};
        `IDX_REMOTE_ADDR:       s_axi_rdata <= {24'h000000, remote_addr_r};
        `IDX_STRAP_STATUS:      s_axi_rdata <= {24'h000000, strap_status};
        `IDX_PIXEL_RATE:        s_axi_rdata <= {24'h000000, pixel_rate_mhz};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `AXI_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************
  // mode outputs
  // ****************************************
  wire src_sel  = display_id_bridge_control_r[`BIT_DISPLAY_ID_SOURCE];
  wire forced1  = link_pairing_control_r[`BIT_FORCED_SINGLE];
  wire ctrl_req = link_pairing_control_r[`BIT_SECOND_CTRL_CHAN];
  // secondary link use: requested, receiver able, not forced single
  wire sec_ok   = !forced1 && ctrl_req && receiver_ctrl_capable;

  // registered decode of the active configuration
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      use_remote_display_id         <= 1'b0;
      use_internal_display_id       <= 1'b0;
      use_external_display_id       <= 1'b0;
      copy_remote_to_internal       <= 1'b0;
      auto_sleep_enable             <= 1'b0;
      aux_audio_mix                 <= 1'b0;
      external_control_override     <= 1'b0;
      cable_type_select             <= 1'b0;
      secondary_tx_enable           <= 1'b0;
      secondary_back_channel_enable <= 1'b0;
      secondary_ctrl_channel        <= 1'b0;
      rate_ok                       <= 1'b0;
      remote_display_id_addr        <= `RST_REMOTE_ADDR;
      strap_latched                 <= 1'b0;
    end
    else
    begin
      // display id source steering
      use_external_display_id <= src_sel; // RULE4
      use_remote_display_id   <= !src_sel && remote_id_found; // RULE3
      use_internal_display_id <= !src_sel && !remote_id_found; // RULE3
      copy_remote_to_internal <= !src_sel && remote_id_found &&
                                 bridge_configuration_r[`BIT_REMOTE_ID_LOAD]; // RULE13
      // stored mode bits passed straight out
      auto_sleep_enable       <= sleep_control_r[`BIT_AUTO_SLEEP]; // RULE6
      aux_audio_mix           <= bridge_configuration_r[`BIT_AUX_AUDIO]; // RULE7
      external_control_override <= bridge_configuration_r[`BIT_EXT_OVERRIDE]; // RULE9
      cable_type_select       <= link_pairing_control_r[`BIT_CABLE_TYPE]; // RULE11
      // secondary link parts follow one enable
      secondary_tx_enable     <= sec_ok; // RULE19
      secondary_back_channel_enable <= sec_ok; // RULE19
      secondary_ctrl_channel  <= sec_ok; // RULE18
      // new receiver up to 96 MHz, legacy strictly below 85 MHz
      rate_ok <= receiver_new_gen ? (pixel_rate_mhz <= `RATE_MAX_NEW_MHZ) // RULE16
                                  : (pixel_rate_mhz < `RATE_LEGACY_MHZ); // RULE17
      // mirrors of the stored address and latch flag
      remote_display_id_addr  <= remote_addr_r;
      strap_latched           <= latched_r;
    end
  end

endmodule

/* tb/strap_divider_model.sv */
module strap_divider_model
(
  input  wire [2:0] level,
  output wire [6:0] above
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // resistor divider on one strap pin
  // ****************************************
  // divider ratio sets level; comparator i trips once level exceeds i
  assign above = ~(7'h7F << level);
endmodule

/* tb/strap_mode_config_monitor.sv */
module strap_mode_config_monitor
(
  input wire        aclk,
  input wire        aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        receiver_new_gen,
  input wire [7:0]  pixel_rate_mhz,
  input wire        use_remote_display_id,
  input wire        use_internal_display_id,
  input wire        use_external_display_id,
  input wire        secondary_tx_enable,
  input wire        secondary_back_channel_enable,
  input wire        rate_ok,
  input wire        strap_latched
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // port checks
  // ****************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_forced_write;
    s_wr_taken ##0 (s_axi_awaddr == 32'h16C && s_axi_wdata[0]);
  endsequence
  property p_write_answer;
    s_wr_taken |-> ##2 s_axi_bvalid;
  endproperty
  property p_write_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_read_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  property p_bresp_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_rdata_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_id_source;
    strap_latched && $past(strap_latched) |->
      $onehot({use_remote_display_id, use_internal_display_id, use_external_display_id});
  endproperty
  property p_forced_single;
    s_forced_write |-> ##[1:3] !secondary_tx_enable && !secondary_back_channel_enable;
  endproperty
  property p_rate_legacy;
    (!receiver_new_gen && pixel_rate_mhz >= 8'h55) [*2] |-> !rate_ok;
  endproperty
  property p_rate_new;
    (receiver_new_gen && pixel_rate_mhz > 8'h60) [*2] |-> !rate_ok;
  endproperty
  property p_latch_stays;
    strap_latched |=> strap_latched;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("no write answer");
  a_bresp_hold: assert property (p_bresp_hold) else $error("write answer dropped");
  a_read_answer: assert property (p_read_answer) else $error("no read answer");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_id_source: assert property (p_id_source) else $error("id source not single");
  a_forced_single: assert property (p_forced_single) else $error("secondary on");
  a_rate_legacy: assert property (p_rate_legacy) else $error("legacy rate ok");
  a_rate_new: assert property (p_rate_new) else $error("new rate ok");
  a_latch_stays: assert property (p_latch_stays) else $error("latch lost");
  a_write_done: assert property (p_write_done) else $error("write answer repeated");
  a_read_done: assert property (p_read_done) else $error("read answer repeated");
endmodule

bind strap_mode_config strap_mode_config_monitor u_mon
(
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .receiver_new_gen, .pixel_rate_mhz, .use_remote_display_id, .use_internal_display_id,
  .use_external_display_id, .secondary_tx_enable, .secondary_back_channel_enable,
  .rate_ok, .strap_latched
);

/* tb/strap_mode_config_test.sv */
`include "strap_mode_config_defs.vh"

module strap_mode_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // design, dividers and stimulus
  // ****************************************
  reg         aclk = 1'h0;
  reg         aresetn = 1'h0;
  reg  [2:0]  lvl0 = 3'h0;
  reg  [2:0]  lvl1 = 3'h0;
  reg         remote_id_found = 1'h0;
  reg         receiver_new_gen = 1'h0;
  reg         receiver_ctrl_capable = 1'h0;
  reg  [7:0]  pixel_rate_mhz = 8'h00;
  reg  [31:0] s_axi_awaddr = 32'h0;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg  [31:0] s_axi_araddr = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'h0;
  reg         s_axi_awvalid = 1'h0;
  reg         s_axi_wvalid = 1'h0;
  reg         s_axi_bready = 1'h0;
  reg         s_axi_arvalid = 1'h0;
  reg         s_axi_rready = 1'h0;
  wire [6:0]  strap0_above;
  wire [6:0]  strap1_above;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        use_remote_display_id, use_internal_display_id, use_external_display_id;
  wire        copy_remote_to_internal, auto_sleep_enable, aux_audio_mix;
  wire        external_control_override, cable_type_select, secondary_tx_enable;
  wire        secondary_back_channel_enable, secondary_ctrl_channel, rate_ok, strap_latched;
  wire [7:0]  remote_display_id_addr;
  int         mismatches = 0;
  int         checks = 0;
  int         i;
  reg  [31:0] d;
  reg  [1:0]  r;
  reg  [9:0]  rt;
  // rate table entries: {new receiver, rate, expected ok}
  localparam [39:0] RATES = {10'h2C1, 10'h2C2, 10'h0A9, 10'h0AA};

  strap_divider_model u_div0 (.level(lvl0), .above(strap0_above));
  strap_divider_model u_div1 (.level(lvl1), .above(strap1_above));
  strap_mode_config u_dut
  (
    .aclk, .aresetn, .strap0_above, .strap1_above, .remote_id_found, .receiver_new_gen,
    .receiver_ctrl_capable, .pixel_rate_mhz, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .use_remote_display_id, .use_internal_display_id, .use_external_display_id,
    .copy_remote_to_internal, .auto_sleep_enable, .aux_audio_mix,
    .external_control_override, .cable_type_select, .secondary_tx_enable,
    .secondary_back_channel_enable, .secondary_ctrl_channel, .rate_ok,
    .remote_display_id_addr, .strap_latched
  );

  // 50 MHz clock
  always #10 aclk = ~aclk;

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string what, input [31:0] seen, input [31:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // bready raised with the request and held until the answer is taken
  task automatic axi_write(input [7:0] idx, input [7:0] val, output [1:0] resp);
    reg aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, idx, 2'h0};
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= {24'h0, val};
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    b = 1'h0;
    while (!b)
    begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
      if (b) s_axi_bready <= 1'h0;
    end
  endtask

  // rready raised with the request and held until the answer is taken
  task automatic axi_read(input [7:0] idx, output [31:0] data, output [1:0] resp);
    reg ar, rd;
    @(posedge aclk);
    s_axi_araddr <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    rd = 1'h0;
    while (!rd)
    begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      rd = s_axi_rvalid && s_axi_rready;
      data = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'h0;
      if (rd) s_axi_rready <= 1'h0;
    end
  endtask

  task automatic rd_chk(input [7:0] idx, input [7:0] exp);
    reg [31:0] data;
    reg [1:0]  resp;
    axi_read(idx, data, resp);
    check("read data", data, {24'h0, exp});
    check("read resp", {30'h0, resp}, {30'h0, `AXI_OKAY});
  endtask

  task automatic wr(input [7:0] idx, input [7:0] val);
    reg [1:0] resp;
    axi_write(idx, val, resp);
    check("write resp", {30'h0, resp}, {30'h0, `AXI_OKAY});
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic do_reset;
    int n;
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    for (n = 0; n < 200 && strap_latched !== 1'h1; n = n + 1)
      @(negedge aclk);
    check("latched", {31'h0, strap_latched}, 32'h1);
  endtask

  function automatic [31:0] mode_bits;
    mode_bits = {24'h0, use_external_display_id, use_remote_display_id,
      use_internal_display_id, auto_sleep_enable, aux_audio_mix,
      external_control_override, cable_type_select, copy_remote_to_internal};
  endfunction

  // ****************************************
  // tests
  // ****************************************
  // every level on both straps, seen through the status register
  initial
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      lvl0 <= i[2:0];
      lvl1 <= 3'h7 - i[2:0];
      do_reset;
      rd_chk(`IDX_STRAP_STATUS, {2'h1, 3'h7 - i[2:0], i[2:0]});
    end
    lvl0 <= 3'h5;
    lvl1 <= 3'h6;
    do_reset;
    rd_chk(`IDX_SLEEP_CONTROL, 8'h00);
    rd_chk(`IDX_DISPLAY_ID_BRIDGE, 8'h01);
    rd_chk(`IDX_BRIDGE_CONFIG, 8'h82);
    rd_chk(`IDX_LINK_PAIRING, 8'h80);
    rd_chk(`IDX_REMOTE_ADDR, 8'hA0);
    @(negedge aclk);
    check("modes", mode_bits(), 32'h8E);
    check("remote addr", {24'h0, remote_display_id_addr}, 32'hA0);
    wr(`IDX_REMOTE_ADDR, 8'hA2);
    check("remote addr", {24'h0, remote_display_id_addr}, 32'hA2);
    @(posedge aclk);
    remote_id_found <= 1'h1;
    wr(`IDX_DISPLAY_ID_BRIDGE, 8'h00);
    check("modes", mode_bits(), 32'h4E);
    @(posedge aclk);
    remote_id_found <= 1'h0;
    repeat (2) @(negedge aclk);
    check("modes", mode_bits(), 32'h2E);
    wr(`IDX_SLEEP_CONTROL, 8'h80);
    check("modes", mode_bits(), 32'h3E);
    @(posedge aclk);
    remote_id_found <= 1'h1;
    wr(`IDX_BRIDGE_CONFIG, 8'h20);
    check("modes", mode_bits(), 32'h53);
    @(posedge aclk);
    lvl0 <= 3'h0;
    lvl1 <= 3'h0;
    repeat (40) @(posedge aclk);
    rd_chk(`IDX_STRAP_STATUS, 8'h75);
    rd_chk(`IDX_BRIDGE_CONFIG, 8'h20);
    receiver_ctrl_capable <= 1'h1;
    wr(`IDX_LINK_PAIRING, 8'h02);
    check("secondary", {28'h0, cable_type_select, secondary_tx_enable,
      secondary_back_channel_enable, secondary_ctrl_channel}, 32'h7);
    wr(`IDX_LINK_PAIRING, 8'h03);
    check("secondary", {29'h0, secondary_tx_enable,
      secondary_back_channel_enable, secondary_ctrl_channel}, 32'h0);
    rd_chk(`IDX_LINK_PAIRING, 8'h03);
    for (i = 0; i < 4; i = i + 1)
    begin
      rt = RATES[(3 - i) * 10 +: 10];
      @(posedge aclk);
      receiver_new_gen <= rt[9];
      pixel_rate_mhz <= rt[8:1];
      repeat (3) @(negedge aclk);
      check("rate ok", {31'h0, rate_ok}, {31'h0, rt[0]});
    end
    rd_chk(`IDX_PIXEL_RATE, 8'h55);
    axi_read(8'h10, d, r);
    check("unmapped read", {r, d[29:0]}, {`AXI_SLVERR, 30'h0});
    axi_write(8'h10, 8'hFF, r);
    check("unmapped write", {30'h0, r}, {30'h0, `AXI_SLVERR});
    test_done;
  end

  // cuts a hang short
  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches = mismatches + 1;
    test_done;
  end
endmodule
